// ==== core/dma_pkg.sv ====
// constants, layouts and types shared by the four-channel dma controller
package dma_pkg;
    // register index within a channel; byte address is four times the index
    localparam logic [2:0]  REG_CONTROL      = 3'h0;
    localparam logic [2:0]  REG_COUNT        = 3'h1;
    localparam logic [2:0]  REG_DEST         = 3'h2;
    localparam logic [2:0]  REG_SOURCE       = 3'h3;
    localparam logic [2:0]  REG_LIST         = 3'h4;
    localparam int          REG_INDEX_W      = 3;
    // transfer width and pointer step codes
    localparam logic [1:0]  WIDTH_BYTE       = 2'h0;
    localparam logic [1:0]  WIDTH_WORD       = 2'h1;
    localparam logic [1:0]  WIDTH_QUAD       = 2'h2;
    localparam logic [1:0]  STEP_FIXED       = 2'h0;
    localparam logic [1:0]  STEP_UP          = 2'h1;
    localparam logic [1:0]  STEP_DOWN        = 2'h2;
    localparam logic [23:0] SIZE_BYTE        = 24'h000001;
    localparam logic [23:0] SIZE_WORD        = 24'h000002;
    localparam logic [23:0] SIZE_QUAD        = 24'h000004;
    // descriptor layout; count sits in the upper half of the first quad
    localparam logic [23:0] DESC_SIZE        = 24'h000010;
    localparam logic [23:0] DESC_OFS_CONTROL = 24'h000000;
    localparam logic [23:0] DESC_OFS_COUNT   = 24'h000002;
    localparam logic [23:0] DESC_OFS_DEST    = 24'h000004;
    localparam logic [23:0] DESC_OFS_SOURCE  = 24'h000008;
    localparam logic [23:0] DESC_OFS_LINK    = 24'h00000C;
    localparam int          DESC_COUNT_LSB   = 16;
    // reset values, and the count value of the last transfer
    localparam logic [15:0] CONTROL_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [23:0] PTR_RESET        = 24'h000000;
    localparam logic [15:0] COUNT_LAST       = 16'h0001;

    typedef struct packed {
        logic [3:0] command_status_field;
        logic       halt;
        logic       frame_end;
        logic       next_link_select;
        logic       end_of_buffer_irq_enable;
        logic [1:0] source_step_field;
        logic [1:0] destination_step_field;
        logic [1:0] transfer_width_field;
        logic       loop;
        logic       channel_enable_bit;
    } channel_control_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } mem_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_READ   = 3'b001,
        ST_WRITE  = 3'b011,
        ST_STATUS = 3'b010,
        ST_CLOSE  = 3'b110,
        ST_WBACK  = 3'b111,
        ST_FETCH  = 3'b100
    } engine_state_t;
endpackage : dma_pkg

// ==== core/dma_controller.sv ====
// four-channel dma controller with avalon-mm register slave and memory master
`timescale 1ns/10ps
module dma_controller
    import dma_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                srst,
    // avalon-mm register slave
    input  wire logic [$clog2(NUM_CH)+REG_INDEX_W-1:0] avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [31:0]                         avs_writedata,
    input  wire logic [3:0]                          avs_byteenable,
    output logic      [31:0]                         avs_readdata,
    output logic                                     avs_waitrequest,
    // memory master
    output mem_cmd_t                                 mem_cmd,
    input  wire logic [31:0]                         mem_rdata,
    input  wire logic                                mem_ready,
    // peripheral side, one lane per channel
    input  wire logic [NUM_CH-1:0]                   req,
    input  wire logic [NUM_CH-1:0]                   req_eof,
    input  wire logic [NUM_CH-1:0][3:0]              peripheral_status_bus,
    output logic      [NUM_CH-1:0]                   ack,
    output logic      [NUM_CH-1:0]                   command_valid,
    output logic      [NUM_CH-1:0][3:0]              command_bus,
    output logic      [NUM_CH-1:0]                   frame_end_strobe,
    output logic      [NUM_CH-1:0]                   status_read_strobe,
    // one-cycle request to the cpu per channel
    output logic      [NUM_CH-1:0]                   buffer_irq
);
    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    // per-channel registers, 16 and 24 bits, and one-bit flags per channel
    channel_control_t ctl_q [NUM_CH];
    channel_control_t ctl_d [NUM_CH];
    logic [15:0]      cnt_q [NUM_CH];
    logic [15:0]      cnt_d [NUM_CH];
    logic [23:0]      dst_q [NUM_CH];
    logic [23:0]      dst_d [NUM_CH];
    logic [23:0]      src_q [NUM_CH];
    logic [23:0]      src_d [NUM_CH];
    logic [23:0]      lst_q [NUM_CH];
    logic [23:0]      lst_d [NUM_CH];
    logic [23:0]      nxt_q [NUM_CH];
    logic [23:0]      nxt_d [NUM_CH];
    logic [NUM_CH-1:0] linked_q, linked_d;
    logic [NUM_CH-1:0] first_q, first_d;
    logic [NUM_CH-1:0] fetch_q, fetch_d;
    logic [NUM_CH-1:0] early_q, early_d;
    logic [NUM_CH-1:0] irq_q, irq_d;
    // engine and bus state
    engine_state_t    state_q, state_d;
    logic [CH_W-1:0]  cur_q, cur_d;
    logic [1:0]       idx_q, idx_d;
    logic [31:0]      data_q, data_d;
    logic             acc_q, acc_d;
    logic [31:0]      rdata_q, rdata_d;

    function automatic logic [23:0] step_ptr(input logic [23:0] p, input logic [1:0] mode,
                                             input logic [1:0] w);
        logic [23:0] sz;
        sz = (w == WIDTH_WORD) ? SIZE_WORD : (w == WIDTH_QUAD) ? SIZE_QUAD : SIZE_BYTE;
        if (mode == STEP_UP) begin
            return p + sz;
        end else if (mode == STEP_DOWN) begin
            return p - sz;
        end
        // fixed and the reserved code both hold the pointer
        return p;
    endfunction : step_ptr

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // engine, channel registers and register slave
    always_comb begin
        channel_control_t cc;
        logic [CH_W-1:0]  pick;
        logic             any;
        logic [15:0]      ncnt;
        logic [CH_W-1:0]  sch;
        logic [31:0]      w;
        ctl_d    = ctl_q;
        cnt_d    = cnt_q;
        dst_d    = dst_q;
        src_d    = src_q;
        lst_d    = lst_q;
        nxt_d    = nxt_q;
        linked_d = linked_q;
        first_d  = first_q;
        fetch_d  = fetch_q;
        early_d  = early_q;
        irq_d    = '0;
        state_d  = state_q;
        cur_d    = cur_q;
        idx_d    = idx_q;
        data_d   = data_q;
        mem_cmd  = '0;
        cc       = ctl_q[cur_q];
        pick     = '0;
        any      = 1'b0;
        ncnt     = cnt_q[cur_q] - COUNT_LAST;
        sch      = avs_address[REG_INDEX_W +: CH_W];
        w        = 32'h0000_0000;

        unique case (state_q)
            ST_IDLE: begin
                // lowest channel wins; channels served independently
                for (int i = NUM_CH - 1; i >= 0; i--) begin
                    if (fetch_q[i] || (ctl_q[i].channel_enable_bit &&
                        (req_eof[i] || (req[i] && cnt_q[i] != COUNT_RESET)))) begin
                        pick = CH_W'(i);
                        any  = 1'b1;
                    end
                end
                if (any) begin
                    cur_d = pick;
                    if (fetch_q[pick]) begin
                        idx_d   = 2'h0;
                        state_d = ST_FETCH;
                    end else if (req_eof[pick]) begin
                        // early frame end flags the buffer
                        if (cnt_q[pick] != COUNT_RESET) begin
                            ctl_d[pick].frame_end = 1'b1;
                            early_d[pick]         = 1'b1;
                            state_d               = ST_STATUS;
                        end else begin
                            state_d = ctl_q[pick].frame_end ? ST_STATUS : ST_CLOSE;
                        end
                    end else begin
                        state_d = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // read phase, then a separate write phase
                mem_cmd.req  = 1'b1;
                mem_cmd.size = cc.transfer_width_field;
                mem_cmd.addr = src_q[cur_q];
                if (mem_ready) begin
                    data_d  = mem_rdata;
                    state_d = ST_WRITE;
                end
            end
            ST_WRITE: begin
                mem_cmd.req   = 1'b1;
                mem_cmd.we    = 1'b1;
                mem_cmd.size  = cc.transfer_width_field;
                mem_cmd.addr  = dst_q[cur_q];
                mem_cmd.wdata = data_q;
                if (mem_ready) begin
                    src_d[cur_q]   = step_ptr(src_q[cur_q], cc.source_step_field,
                                              cc.transfer_width_field);
                    dst_d[cur_q]   = step_ptr(dst_q[cur_q], cc.destination_step_field,
                                              cc.transfer_width_field);
                    cnt_d[cur_q]   = ncnt;
                    first_d[cur_q] = 1'b0;
                    // watermark compare on the new count
                    if (!linked_q[cur_q] && cc.end_of_buffer_irq_enable &&
                        lst_q[cur_q][23:16] != 8'h00 && ncnt[15:8] == 8'h00 &&
                        ncnt[7:0] == lst_q[cur_q][23:16]) begin
                        irq_d[cur_q] = 1'b1;
                    end
                    if (cnt_q[cur_q] == COUNT_LAST) begin
                        state_d = cc.frame_end ? ST_STATUS : ST_CLOSE;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_STATUS: begin
                // wait for the peripheral to close the frame
                if (req_eof[cur_q]) begin
                    ctl_d[cur_q].command_status_field = peripheral_status_bus[cur_q];
                    state_d = ST_CLOSE;
                end
            end
            ST_CLOSE: begin
                irq_d[cur_q]   = cc.end_of_buffer_irq_enable | early_q[cur_q];
                early_d[cur_q] = 1'b0;
                if (!(linked_q[cur_q] && cc.loop)) begin
                    ctl_d[cur_q].channel_enable_bit = 1'b0;
                end
                if (linked_q[cur_q] && !cc.loop) begin
                    state_d = ST_WBACK;
                end else begin
                    state_d = ST_IDLE;
                    if (linked_q[cur_q]) begin
                        lst_d[cur_q]   = cc.next_link_select ? nxt_q[cur_q]
                                                             : lst_q[cur_q] + DESC_SIZE;
                        // halt leaves the next one unfetched
                        fetch_d[cur_q] = ~cc.halt;
                    end
                end
            end
            ST_WBACK: begin
                // control word written back to the descriptor
                mem_cmd.req   = 1'b1;
                mem_cmd.we    = 1'b1;
                mem_cmd.size  = WIDTH_WORD;
                mem_cmd.addr  = lst_q[cur_q] + DESC_OFS_CONTROL;
                mem_cmd.wdata = {16'h0000, cc};
                if (mem_ready) begin
                    lst_d[cur_q]   = cc.next_link_select ? nxt_q[cur_q]
                                                         : lst_q[cur_q] + DESC_SIZE;
                    // halt leaves the next one unfetched
                    fetch_d[cur_q] = ~cc.halt;
                    state_d        = ST_IDLE;
                end
            end
            ST_FETCH: begin
                // list pointer used only as descriptor address here
                mem_cmd.req  = 1'b1;
                mem_cmd.size = WIDTH_QUAD;
                unique case (idx_q)
                    2'h0: mem_cmd.addr = lst_q[cur_q] + DESC_OFS_CONTROL;
                    2'h1: mem_cmd.addr = lst_q[cur_q] + DESC_OFS_DEST;
                    2'h2: mem_cmd.addr = lst_q[cur_q] + DESC_OFS_SOURCE;
                    2'h3: mem_cmd.addr = lst_q[cur_q] + DESC_OFS_LINK;
                endcase
                if (mem_ready) begin
                    idx_d = idx_q + 2'h1;
                    unique case (idx_q)
                        2'h0: begin
                            ctl_d[cur_q] = channel_control_t'(mem_rdata[15:0]);
                            cnt_d[cur_q] = mem_rdata[DESC_COUNT_LSB +: 16];
                        end
                        2'h1: dst_d[cur_q] = mem_rdata[23:0];
                        2'h2: src_d[cur_q] = mem_rdata[23:0];
                        2'h3: begin
                            nxt_d[cur_q]    = mem_rdata[23:0];
                            linked_d[cur_q] = cc.channel_enable_bit;
                            first_d[cur_q]  = 1'b1;
                            fetch_d[cur_q]  = 1'b0;
                            state_d         = ST_IDLE;
                        end
                    endcase
                end
            end
            default: state_d = ST_IDLE;
        endcase

        // register slave: one wait state, read data captured on the first cycle
        acc_d   = (avs_read | avs_write) & ~acc_q;
        rdata_d = rdata_q;
        if (sch < CH_W'(NUM_CH - 1) || sch == CH_W'(NUM_CH - 1)) begin
            unique case (avs_address[REG_INDEX_W-1:0])
                REG_CONTROL: w = {16'h0000, ctl_q[sch]};
                REG_COUNT:   w = {16'h0000, cnt_q[sch]};
                REG_DEST:    w = {8'h00, dst_q[sch]};
                REG_SOURCE:  w = {8'h00, src_q[sch]};
                REG_LIST:    w = {8'h00, lst_q[sch]};
                default:     w = 32'h0000_0000;
            endcase
            // software writes take priority over engine updates
            if (acc_q && avs_write) begin
                unique case (avs_address[REG_INDEX_W-1:0])
                    REG_CONTROL: begin
                        ctl_d[sch] = channel_control_t'(16'(merge(w, avs_writedata,
                                                                  avs_byteenable)));
                        if (ctl_d[sch].channel_enable_bit) begin
                            linked_d[sch] = 1'b0;
                            first_d[sch]  = 1'b1;
                        end
                    end
                    REG_COUNT:  cnt_d[sch] = 16'(merge(w, avs_writedata, avs_byteenable));
                    REG_DEST:   dst_d[sch] = 24'(merge(w, avs_writedata, avs_byteenable));
                    REG_SOURCE: src_d[sch] = 24'(merge(w, avs_writedata, avs_byteenable));
                    REG_LIST: begin
                        lst_d[sch] = 24'(merge(w, avs_writedata, avs_byteenable));
                        // low byte lane starts a descriptor fetch
                        if (avs_byteenable[0]) begin
                            fetch_d[sch] = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (acc_d && avs_read) begin
            rdata_d = w;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctl_q[i] <= channel_control_t'(CONTROL_RESET);
                cnt_q[i] <= COUNT_RESET;
                dst_q[i] <= PTR_RESET;
                src_q[i] <= PTR_RESET;
                lst_q[i] <= PTR_RESET;
                nxt_q[i] <= PTR_RESET;
            end
            linked_q <= '0;
            first_q  <= '0;
            fetch_q  <= '0;
            early_q  <= '0;
            irq_q    <= '0;
            state_q  <= ST_IDLE;
            cur_q    <= '0;
            idx_q    <= 2'h0;
            data_q   <= 32'h0000_0000;
            acc_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            ctl_q    <= ctl_d;
            cnt_q    <= cnt_d;
            dst_q    <= dst_d;
            src_q    <= src_d;
            lst_q    <= lst_d;
            nxt_q    <= nxt_d;
            linked_q <= linked_d;
            first_q  <= first_d;
            fetch_q  <= fetch_d;
            early_q  <= early_d;
            irq_q    <= irq_d;
            state_q  <= state_d;
            cur_q    <= cur_d;
            idx_q    <= idx_d;
            data_q   <= data_d;
            acc_q    <= acc_d;
            rdata_q  <= rdata_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~acc_q;
    assign buffer_irq      = irq_q;

    // per-channel peripheral handshake
    for (genvar g = 0; g < NUM_CH; g++) begin : g_lane
        logic mine;
        assign mine = (cur_q == CH_W'(g));
        assign ack[g] = mine && (state_q == ST_READ || state_q == ST_WRITE ||
                                 (state_q == ST_STATUS && req_eof[g]));
        // command valid on the first write
        assign command_valid[g] = mine && state_q == ST_WRITE && mem_ready && first_q[g];
        assign command_bus[g] = ctl_q[g].command_status_field;
        // last transfer of a frame-end buffer
        assign frame_end_strobe[g] = mine && state_q == ST_WRITE &&
                                     cnt_q[g] == COUNT_LAST && ctl_q[g].frame_end;
        assign status_read_strobe[g] = mine && state_q == ST_STATUS && req_eof[g];
    end
endmodule : dma_controller

// ==== verif/dma_mem_model.sv ====
// byte memory that answers the dma master after a chosen lag
`timescale 1ns/10ps
module dma_mem_model
    import dma_pkg::*;
(
    // master side
    input  wire logic        core_clk,
    input  mem_cmd_t         mem_cmd,
    input  wire logic [1:0]  lag,
    output logic      [31:0] mem_rdata,
    output logic             mem_ready
);
    logic [7:0]  mem [0:255];
    logic [1:0]  wait_q = 2'h0;
    logic [31:0] last_q;
    logic [7:0]  a;
    assign a = mem_cmd.addr[7:0];
    assign mem_ready = mem_cmd.req && wait_q == lag;
    // stale data toggles so a late sample cannot pass
    assign mem_rdata = mem_ready ? {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1], mem[a]} : ~last_q;
    always @(posedge core_clk) begin
        wait_q <= (mem_ready || !mem_cmd.req) ? 2'h0 : wait_q + 2'h1;
        last_q <= mem_rdata;
        for (int i = 0; i < 4; i++) begin
            if (mem_ready && mem_cmd.we && i < (1 << mem_cmd.size))
                mem[a + 8'(i)] <= mem_cmd.wdata[8*i +: 8];
        end
    end
endmodule : dma_mem_model

// ==== verif/dma_controller_chk.sv ====
// port assertions for the dma controller, watching channel 0, the shared memory master and the ack lanes of all channels
`timescale 1ns/10ps
module dma_controller_chk
    import dma_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic              core_clk,
    input wire logic              srst,
    input mem_cmd_t               mem_cmd,
    input wire logic              mem_ready,
    input wire logic [NUM_CH-1:0] req_eof,
    input wire logic [NUM_CH-1:0] ack,
    input wire logic [NUM_CH-1:0] command_valid,
    input wire logic [NUM_CH-1:0] frame_end_strobe,
    input wire logic [NUM_CH-1:0] status_read_strobe,
    input wire logic [NUM_CH-1:0] buffer_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_cmd_with_ack: assert property (
        command_valid[0] |-> ack[0] && mem_cmd.we && mem_ready) else $error("command valid alone");
    a_cmd_once: assert property (
        command_valid[0] |=> !command_valid[0]) else $error("command valid too long");
    a_eof_on_write: assert property (
        frame_end_strobe[0] |-> ack[0] && mem_cmd.req && mem_cmd.we) else $error("stray frame end");
    a_status_ack: assert property (
        status_read_strobe[0] |-> ack[0] && req_eof[0]) else $error("status read unacked");
    a_irq_pulse: assert property (
        buffer_irq[0] |=> !buffer_irq[0]) else $error("irq not a pulse");
    a_read_then_write: assert property (
        mem_cmd.req && !mem_cmd.we && mem_ready && ack[0] |=> mem_cmd.req && mem_cmd.we)
        else $error("transfer write missing");
    a_mem_hold: assert property (
        mem_cmd.req && !mem_ready |=> $stable(mem_cmd)) else $error("memory request moved");
    a_one_channel: assert property (
        $onehot0(ack)) else $error("two channels acknowledged");
endmodule : dma_controller_chk

// ==== verif/dma_controller_test.sv ====
// self-checking bench for the four-channel dma controller
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module four_channel_dma_controller_test;
    import dma_pkg::*;
    logic            core_clk, srst, avs_read, avs_write, avs_waitrequest, mem_ready;
    logic [4:0]      avs_address;
    logic [31:0]     avs_writedata, avs_readdata, mem_rdata, rd;
    logic [3:0]      avs_byteenable, cv_cmd, req, req_eof, ack, command_valid;
    logic [3:0]      frame_end_strobe, status_read_strobe, buffer_irq;
    logic [3:0][3:0] peripheral_status_bus, command_bus;
    logic [1:0]      lag;
    logic [127:0]    desc;
    mem_cmd_t        mem_cmd;
    int              n_fail, n_checks, cv_n, irq_n;
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    dma_controller #(.NUM_CH(4)) dma_controller_i (.core_clk, .srst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_cmd,
        .mem_rdata, .mem_ready, .req, .req_eof, .peripheral_status_bus, .ack, .command_valid,
        .command_bus, .frame_end_strobe, .status_read_strobe, .buffer_irq);
    dma_mem_model dma_mem_model_i (.core_clk, .mem_cmd, .lag, .mem_rdata, .mem_ready);
    always @(posedge core_clk) begin
        if (command_valid[0] === 1'b1) begin
            cv_n++;
            cv_cmd = command_bus[0];
        end
        if (buffer_irq[0] === 1'b1) irq_n++;
    end
    // one register access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
        @(posedge core_clk);
        avs_address   <= adr;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6000) @(posedge core_clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, req, req_eof} = '0;
        {srst, avs_byteenable, peripheral_status_bus, lag} = {1'b1, 4'hF, 16'h0, 2'h1};
        for (int i = 0; i < 256; i++) dma_mem_model_i.mem[i] = 8'(i);
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        bus(0, 5'h09, 0); `CHK(rd, 32'h0)
        bus(1, 5'h0A, 32'hFFFFFFFF); bus(0, 5'h0A, 0); `CHK(rd, 32'h00FFFFFF)
        bus(1, 5'h08, 32'hFFFFFFFE); bus(0, 5'h08, 0); `CHK(rd, 32'h0000FFFE)
        bus(1, 5'h0D, 32'h1234); bus(0, 5'h0D, 0); `CHK(rd, 32'h0)
        $display("test registers done");
        bus(1, 5'h03, 32'h10); bus(1, 5'h02, 32'h40); bus(1, 5'h01, 32'h3);
        avs_byteenable <= 4'h4;
        bus(1, 5'h04, 32'h020000);
        avs_byteenable <= 4'hF;
        req <= 4'h1;
        bus(1, 5'h00, 32'hA565);
        // a hang here is ended by the watchdog
        while (frame_end_strobe[0] !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        {req, req_eof, peripheral_status_bus[0]} <= {4'h0, 4'h1, 4'h5};
        while (irq_n < 2) @(negedge core_clk);
        @(posedge core_clk);
        req_eof <= 4'h0;
        bus(0, 5'h03, 0); `CHK(rd, 32'h16)
        bus(0, 5'h02, 0); `CHK(rd, 32'h3A)
        bus(0, 5'h01, 0); `CHK(rd, 32'h0)
        bus(0, 5'h00, 0); `CHK(rd, 32'h5564)
        bus(0, 5'h04, 0); `CHK(rd, 32'h020000)
        `CHK({dma_mem_model_i.mem[8'h3D], dma_mem_model_i.mem[8'h3C]}, 16'h1514)
        `CHK(cv_n, 1)
        `CHK(cv_cmd, 4'hA)
        `CHK(irq_n, 2)
        $display("test direct done");
        desc = {32'hD0, 32'hA0, 32'hC0, 32'h00023B4B};
        for (int i = 0; i < 16; i++) dma_mem_model_i.mem[8'h80 + i] = desc[8*i +: 8];
        lag <= 2'h0;
        req <= 4'h4;
        bus(1, 5'h14, 32'h80);
        while (buffer_irq[2] !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        req <= 4'h0;
        bus(0, 5'h10, 0); `CHK(rd, 32'h3B4B)
        bus(0, 5'h11, 0); `CHK(rd, 32'h0)
        bus(0, 5'h12, 0); `CHK(rd, 32'hC0)
        bus(0, 5'h13, 0); `CHK(rd, 32'hA8)
        bus(0, 5'h14, 0); `CHK(rd, 32'hD0)
        `CHK(dma_mem_model_i.mem[8'h80], 8'h4B)
        `CHK(dma_mem_model_i.mem[8'hC0], 8'hA4)
        $display("test linked done");
        print_verdict();
    end
endmodule : four_channel_dma_controller_test
bind dma_controller dma_controller_chk #(.NUM_CH(NUM_CH)) dma_controller_chk_i (.core_clk, .srst,
    .mem_cmd, .mem_ready, .req_eof, .ack, .command_valid, .frame_end_strobe,
    .status_read_strobe, .buffer_irq);
